/* File: verilog/smb_consts.svh */
// Register offsets, field positions and reset values of the SMBus byte transfer engine.
// Assumes an APB slave with 32-bit data and byte addresses; included by bare name.
`ifndef SMB_CONSTS_SVH
`define SMB_CONSTS_SVH

`define SMB_OFF_CTRL 8'h00
`define SMB_OFF_STATUS 8'h04
`define SMB_OFF_DATA 8'h08
`define SMB_OFF_ADDR 8'h0C

`define SMB_CTRL_ENABLE 0
`define SMB_CTRL_MASTER_SELECT 1
`define SMB_CTRL_ACK_DRIVE 2
`define SMB_CTRL_IRQ_ENABLE 3

`define SMB_STAT_COMPLETE 0
`define SMB_STAT_ADDRESSED 1
`define SMB_STAT_BUS_BUSY 2
`define SMB_STAT_SLAVE_TX 3
`define SMB_STAT_MASTER 4

`define SMB_OWN_ADDR_RESET 7'h00
`define SMB_LINE_IDLE 1'b1
`define SMB_LAST_BIT 3'h7

`endif

/* File: verilog/smb_pkg.sv */
// Types shared by the SMBus byte transfer engine and its input synchroniser.
// Assumes the constants header supplies all numeric offsets and fields.
package smb_pkg;

  typedef enum logic [7:0] {
    st_idle = 8'h01,
    st_header = 8'h02,
    st_ack_header = 8'h04,
    st_receive_byte = 8'h08,
    st_ack_receive = 8'h10,
    st_transmit_byte = 8'h20,
    st_wait_ack = 8'h40,
    st_stop = 8'h80
  } smb_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } smb_sync_bit_t;

  typedef struct packed {
    smb_state_t state;
    logic [2:0] bit_counter;
    logic [7:0] header_shift;
    logic [7:0] data_shift;
    logic [7:0] byte_data_register;
    logic [6:0] own_slave_address;
    logic enable;
    logic master_select_bit;
    logic ack_drive_bit;
    logic irq_enable;
    logic transfer_complete_flag;
    logic addressed_as_slave_flag;
    logic bus_busy_flag;
    logic is_master;
    logic slave_transmit;
    logic got_bit;
    logic sampled_bit;
    logic scl_prev;
    logic sda_prev;
    logic sda_out;
    logic sda_oe;
    logic stop_request;
    logic start_seen;
    logic stop_seen;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } smb_regs_t;

endpackage : smb_pkg

/* File: verilog/smb_sync.sv */
// Three-stage input synchroniser with agreement filter, one lane per bit.
// Assumes asynchronous inputs; the filtered level moves only when stages two and three agree.
`timescale 1ns/1ps
module smb_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
      smb_pkg::smb_sync_bit_t r;
      smb_pkg::smb_sync_bit_t next_r;
      always_comb begin
        next_r = r;
        next_r.s1 = din[i];
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (r.s2 == r.s3) begin
          next_r.q = r.s3;
        end
      end
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          r <= {4{RESET_LEVEL[i]}};
        end else if (ce) begin
          r <= next_r;
        end
      end
      assign q[i] = r.q;
    end
  endgenerate

endmodule : smb_sync

/* File: verilog/smb_byte_fsm.sv */
// SMBus byte transfer engine: header, acknowledge and data phases with an APB register file.
// Assumes an external SCL/START/STOP generator on clk that takes stop_request and reports
// arbitration loss, and open-drain pad logic fed by sda_out and sda_oe.
`timescale 1ns/1ps
`include "smb_consts.svh"
module smb_byte_fsm #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic arb_lost,
  output logic master_mode,
  output logic stop_request,
  output logic start_seen,
  output logic stop_seen,
  output logic irq
);

  localparam smb_pkg::smb_regs_t RESET_VAL = '{
    state: smb_pkg::st_idle,
    own_slave_address: `SMB_OWN_ADDR_RESET,
    scl_prev: `SMB_LINE_IDLE,
    sda_prev: `SMB_LINE_IDLE,
    default: '0
  };

  smb_pkg::smb_regs_t r;
  smb_pkg::smb_regs_t next_r;
  logic [1:0] line_q;

  // Both bus lines are asynchronous to clk, so they are filtered before edge detection.
  smb_sync #(
    .WIDTH(2),
    .RESET_LEVEL(2'h3)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .din({sda_in, scl_in}),
    .q(line_q)
  );

  always_comb begin
    logic scl_f;
    logic sda_f;
    logic fall;
    logic rise;
    logic start_c;
    logic stop_c;
    logic b;
    logic last;
    logic match;
    logic drive;
    logic acc;
    logic wr;
    logic [7:0] off;
    logic [7:0] hdr_n;
    scl_f = line_q[0];
    sda_f = line_q[1];
    fall = r.scl_prev & ~scl_f;
    rise = ~r.scl_prev & scl_f;
    start_c = r.scl_prev & scl_f & r.sda_prev & ~sda_f;
    stop_c = r.scl_prev & scl_f & ~r.sda_prev & sda_f;
    b = r.sampled_bit;
    last = (r.bit_counter == `SMB_LAST_BIT);
    hdr_n = {r.header_shift[6:0], b};
    match = (hdr_n[7:1] == r.own_slave_address);
    drive = 1'b0;
    acc = psel & penable;
    wr = acc & r.pready & pwrite;
    off = 8'(paddr);

    next_r = r;
    next_r.scl_prev = scl_f;
    next_r.sda_prev = sda_f;
    next_r.start_seen = start_c;
    next_r.stop_seen = stop_c;
    next_r.sda_out = 1'b0;

    // Software side: a write that completes this cycle.
    if (wr) begin
      case (off)
        `SMB_OFF_CTRL: begin
          next_r.enable = pwdata[`SMB_CTRL_ENABLE];
          next_r.master_select_bit = pwdata[`SMB_CTRL_MASTER_SELECT];
          next_r.ack_drive_bit = pwdata[`SMB_CTRL_ACK_DRIVE];
          next_r.irq_enable = pwdata[`SMB_CTRL_IRQ_ENABLE];
          // A new master request is accepted only on a free bus.
          if (pwdata[`SMB_CTRL_MASTER_SELECT] && !r.master_select_bit && !r.bus_busy_flag) begin
            next_r.is_master = 1'b1;
          end
        end
        `SMB_OFF_STATUS: begin
          if (pwdata[`SMB_STAT_COMPLETE]) begin
            next_r.transfer_complete_flag = 1'b0;
          end
        end
        `SMB_OFF_DATA: begin
          next_r.byte_data_register = pwdata[7:0];
        end
        `SMB_OFF_ADDR: begin
          next_r.own_slave_address = pwdata[6:0];
        end
        default: begin
        end
      endcase
    end

    if (arb_lost) begin
      next_r.is_master = 1'b0;
      next_r.master_select_bit = 1'b0;
    end

    // Data is sampled while SCL is high and consumed at the following falling edge.
    if (rise) begin
      next_r.sampled_bit = sda_f;
      next_r.got_bit = 1'b1;
    end

    if (start_c) begin
      next_r.bus_busy_flag = 1'b1;
      next_r.state = smb_pkg::st_header;
      next_r.bit_counter = 3'h0;
      next_r.got_bit = 1'b0;
      next_r.addressed_as_slave_flag = 1'b0;
    end else if (stop_c) begin
      next_r.bus_busy_flag = 1'b0;
      next_r.state = smb_pkg::st_idle;
      next_r.addressed_as_slave_flag = 1'b0;
      next_r.is_master = 1'b0;
      next_r.master_select_bit = 1'b0;
      next_r.got_bit = 1'b0;
    end else if (fall && r.got_bit) begin
      next_r.got_bit = 1'b0;
      case (r.state)
        smb_pkg::st_idle: begin
        end
        smb_pkg::st_header: begin
          next_r.header_shift = hdr_n;
          next_r.bit_counter = r.bit_counter + 3'h1;
          if (last) begin
            next_r.state = smb_pkg::st_ack_header;
            if (match) begin
              next_r.is_master = 1'b0;
              next_r.master_select_bit = 1'b0;
              next_r.addressed_as_slave_flag = 1'b1;
            end
          end
        end
        smb_pkg::st_ack_header: begin
          next_r.bit_counter = 3'h0;
          next_r.slave_transmit = r.addressed_as_slave_flag & r.header_shift[0];
          if (r.addressed_as_slave_flag) begin
            if (r.header_shift[0]) begin
              next_r.state = smb_pkg::st_transmit_byte;
              next_r.data_shift = r.byte_data_register;
            end else begin
              next_r.state = smb_pkg::st_receive_byte;
            end
          end else if (r.is_master) begin
            if (b) begin
              next_r.state = smb_pkg::st_stop;
            end else if (r.header_shift[0]) begin
              next_r.state = smb_pkg::st_receive_byte;
            end else begin
              next_r.state = smb_pkg::st_transmit_byte;
              next_r.data_shift = r.byte_data_register;
            end
          end else begin
            // Not our transfer: wait for the next START or STOP.
            next_r.state = smb_pkg::st_idle;
          end
        end
        smb_pkg::st_receive_byte: begin
          next_r.data_shift = {r.data_shift[6:0], b};
          next_r.bit_counter = r.bit_counter + 3'h1;
          if (last) begin
            next_r.state = smb_pkg::st_ack_receive;
            next_r.byte_data_register = {r.data_shift[6:0], b};
            next_r.transfer_complete_flag = 1'b1;
          end
        end
        smb_pkg::st_ack_receive: begin
          next_r.state = smb_pkg::st_receive_byte;
          next_r.bit_counter = 3'h0;
        end
        smb_pkg::st_transmit_byte: begin
          next_r.data_shift = {r.data_shift[6:0], 1'b0};
          next_r.bit_counter = r.bit_counter + 3'h1;
          if (last) begin
            next_r.state = smb_pkg::st_wait_ack;
            next_r.transfer_complete_flag = 1'b1;
          end
        end
        smb_pkg::st_wait_ack: begin
          next_r.bit_counter = 3'h0;
          if (!b) begin
            next_r.state = smb_pkg::st_transmit_byte;
            next_r.data_shift = r.byte_data_register;
          end else if (r.is_master) begin
            next_r.state = smb_pkg::st_stop;
          end else begin
            next_r.state = smb_pkg::st_idle;
          end
        end
        smb_pkg::st_stop: begin
        end
        default: begin
          next_r.state = smb_pkg::st_idle;
        end
      endcase
    end

    // The stop state waits for the generator's STOP; a slave has nothing to wait for.
    if (r.state == smb_pkg::st_stop && !r.is_master && !start_c) begin
      next_r.state = smb_pkg::st_idle;
    end

    if (!r.enable) begin
      next_r.state = smb_pkg::st_idle;
      next_r.is_master = 1'b0;
      next_r.addressed_as_slave_flag = 1'b0;
    end

    // Open-drain drive, chosen from the state being entered.
    case (next_r.state)
      smb_pkg::st_header: begin
        drive = next_r.is_master & ~r.byte_data_register[3'h7 - next_r.bit_counter];
      end
      smb_pkg::st_ack_header: begin
        drive = next_r.addressed_as_slave_flag & r.ack_drive_bit;
      end
      smb_pkg::st_ack_receive: begin
        drive = r.ack_drive_bit;
      end
      smb_pkg::st_transmit_byte: begin
        drive = ~next_r.data_shift[7];
      end
      default: begin
        drive = 1'b0;
      end
    endcase
    // SDA may only change while SCL is low, or a false START or STOP would appear; idle and stop release it whatever SCL is.
    if (next_r.state == smb_pkg::st_idle || next_r.state == smb_pkg::st_stop) begin
      next_r.sda_oe = 1'b0;
    end else if (!scl_f) begin
      next_r.sda_oe = drive;
    end

    next_r.stop_request = r.is_master & r.enable &
        ((r.state == smb_pkg::st_stop) |
         (!r.master_select_bit & (r.state != smb_pkg::st_idle)));

    // A completed STATUS write cannot clear a flag set in the same cycle.
    next_r.irq = next_r.transfer_complete_flag & next_r.irq_enable;

    // APB: one wait state, then pready for a single cycle.
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    if (acc && !r.pready) begin
      next_r.pready = 1'b1;
      next_r.prdata = 32'h0000_0000;
      case (off)
        `SMB_OFF_CTRL: begin
          next_r.prdata[`SMB_CTRL_ENABLE] = r.enable;
          next_r.prdata[`SMB_CTRL_MASTER_SELECT] = r.master_select_bit;
          next_r.prdata[`SMB_CTRL_ACK_DRIVE] = r.ack_drive_bit;
          next_r.prdata[`SMB_CTRL_IRQ_ENABLE] = r.irq_enable;
        end
        `SMB_OFF_STATUS: begin
          next_r.prdata[`SMB_STAT_COMPLETE] = r.transfer_complete_flag;
          next_r.prdata[`SMB_STAT_ADDRESSED] = r.addressed_as_slave_flag;
          next_r.prdata[`SMB_STAT_BUS_BUSY] = r.bus_busy_flag;
          next_r.prdata[`SMB_STAT_SLAVE_TX] = r.slave_transmit;
          next_r.prdata[`SMB_STAT_MASTER] = r.is_master;
        end
        `SMB_OFF_DATA: begin
          next_r.prdata[7:0] = r.byte_data_register;
        end
        `SMB_OFF_ADDR: begin
          next_r.prdata[6:0] = r.own_slave_address;
        end
        default: begin
          next_r.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= RESET_VAL;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign sda_out = r.sda_out;
  assign sda_oe = r.sda_oe;
  assign master_mode = r.is_master;
  assign stop_request = r.stop_request;
  assign start_seen = r.start_seen;
  assign stop_seen = r.stop_seen;
  assign irq = r.irq;

endmodule : smb_byte_fsm

/* File: bench/smb_byte_fsm_asserts.sv */
// Port checks of the SMBus byte transfer engine.
// Assumes one clk domain with asynchronous active-high reset; bound below.
`timescale 1ns/1ps
module smb_byte_fsm_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic master_mode,
  input wire logic stop_request,
  input wire logic start_seen,
  input wire logic stop_seen
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  chk_ready_next: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused access with data");
  chk_sda_low: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  chk_start_found: assert property ($fell(sda_in) && scl_in |-> ##[3:6] start_seen)
    else $error("start not seen");
  chk_stop_found: assert property ($rose(sda_in) && scl_in |-> ##[3:6] stop_seen)
    else $error("stop not seen");
  chk_start_once: assert property (start_seen |=> !start_seen)
    else $error("start pulse too long");
  chk_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in, 3))
    else $error("sda_oe moved with scl high");
  chk_slave_no_stop: assert property (!master_mode |=> !stop_request)
    else $error("stop request in slave mode");
  chk_stop_drops: assert property (stop_seen |-> !master_mode && !sda_oe)
    else $error("master mode or drive kept after stop");
  cover property (start_seen);
  cover property (stop_seen);
  cover property ($rose(sda_oe));
  cover property (pslverr);
endmodule : smb_byte_fsm_asserts

bind smb_byte_fsm smb_byte_fsm_asserts u_chk (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .master_mode(master_mode),
  .stop_request(stop_request), .start_seen(start_seen), .stop_seen(stop_seen));

/* File: bench/smb_bus_model.sv */
// Remote SMBus master: makes SCL and pulls SDA low on request.
// Assumes the bench forms SDA as a wired-AND with a pull-up.
`timescale 1ns/1ps
module smb_bus_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // A quarter of the 125 ns link period; SCL stands high between frames.
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start_cond();
    sda_low = 1'b1;
    #(Q) scl = 1'b0;
    #(Q);
  endtask : start_cond
  task automatic stop_cond();
    sda_low = 1'b1;
    #(Q) scl = 1'b1;
    #(Q) sda_low = 1'b0;
    #(4 * Q);
  endtask : stop_cond
  // Data moves only while SCL is low, so no false START or STOP appears.
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    #(Q) scl = 1'b1;
    #(Q) s = sda;
    #(Q) scl = 1'b0;
    #(Q);
  endtask : bit_io
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask : xfer
endmodule : smb_bus_model

/* File: bench/smb_byte_fsm_tb.sv */
// Self-checking bench of the SMBus byte transfer engine in slave and master mode.
// Assumes the bus model acts as the remote master; SDA is pulled up here.
`timescale 1ns/1ps
`include "smb_consts.svh"
module smb_byte_fsm_tb;
  typedef struct {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic err;
  } smb_row_t;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, err, ak;
  logic sda_out, sda_oe, master_mode, stop_request, start_seen, stop_seen, irq;
  logic scl, sda_low;
  logic [7:0] paddr, rx;
  logic [31:0] pwdata, prdata, rd;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  wire sda = !(sda_oe || sda_low);
  smb_row_t rows [9] = '{
    '{1'b0, `SMB_OFF_CTRL, 32'h0, 32'h0, 1'b0},
    '{1'b0, `SMB_OFF_STATUS, 32'h0, 32'h0, 1'b0},
    '{1'b0, `SMB_OFF_ADDR, 32'h0, 32'h0, 1'b0},
    '{1'b1, `SMB_OFF_ADDR, 32'h55, 32'h0, 1'b0},
    '{1'b0, `SMB_OFF_ADDR, 32'h0, 32'h55, 1'b0},
    '{1'b1, `SMB_OFF_CTRL, 32'hD, 32'h0, 1'b0},
    '{1'b0, `SMB_OFF_CTRL, 32'h0, 32'hD, 1'b0},
    '{1'b1, 8'h10, 32'hF, 32'h0, 1'b1},
    '{1'b0, 8'h10, 32'h0, 32'h0, 1'b1}};
  smb_byte_fsm u_dut (.clk(clk), .reset(reset), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .arb_lost(1'b0), .master_mode(master_mode), .stop_request(stop_request),
    .start_seen(start_seen), .stop_seen(stop_seen), .irq(irq));
  smb_bus_model u_bus (.scl(scl), .sda_low(sda_low), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
      input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask : rdc
  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("row data", rows[i].e, rd);
      chk("row error", 32'(rows[i].err), 32'(err));
    end
    $display("register rows done");
    u_bus.start_cond();
    u_bus.xfer(8'hAA, 1'b1, rx, ak);
    chk("header ack", 32'h0, 32'(ak));
    rdc(`SMB_OFF_STATUS, 32'h6, 32'h6, "addressed busy");
    rdc(`SMB_OFF_DATA, 32'hFF, 32'h0, "dummy read");
    u_bus.xfer(8'hA5, 1'b1, rx, ak);
    chk("rx ack", 32'h0, 32'(ak));
    rdc(`SMB_OFF_DATA, 32'hFF, 32'hA5, "rx data");
    rdc(`SMB_OFF_STATUS, 32'h1, 32'h1, "complete");
    chk("irq set", 32'h1, 32'(irq));
    apb(1'b1, `SMB_OFF_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq clear", 32'h0, 32'(irq));
    // The host withdraws the acknowledge before the last byte arrives.
    apb(1'b1, `SMB_OFF_CTRL, 32'h9);
    u_bus.xfer(8'h5A, 1'b1, rx, ak);
    chk("last nack", 32'h1, 32'(ak));
    rdc(`SMB_OFF_DATA, 32'hFF, 32'h5A, "second byte");
    u_bus.stop_cond();
    repeat (8) @(posedge clk);
    rdc(`SMB_OFF_STATUS, 32'h6, 32'h0, "after stop");
    $display("slave receive done");
    apb(1'b1, `SMB_OFF_CTRL, 32'hD);
    apb(1'b1, `SMB_OFF_DATA, 32'h3C);
    u_bus.start_cond();
    u_bus.xfer(8'hAB, 1'b1, rx, ak);
    chk("read header ack", 32'h0, 32'(ak));
    rdc(`SMB_OFF_STATUS, 32'hE, 32'hE, "slave transmit");
    u_bus.xfer(8'hFF, 1'b1, rx, ak);
    chk("tx byte", 32'h3C, 32'(rx));
    u_bus.stop_cond();
    $display("slave transmit done");
    u_bus.start_cond();
    u_bus.xfer(8'h20, 1'b1, rx, ak);
    chk("foreign header", 32'h1, 32'(ak));
    u_bus.stop_cond();
    repeat (8) @(posedge clk);
    rdc(`SMB_OFF_STATUS, 32'h6, 32'h0, "foreign idle");
    $display("foreign address done");
    // The model stands in for the SCL and START/STOP generator while this block is master.
    apb(1'b1, `SMB_OFF_DATA, 32'h92);
    apb(1'b1, `SMB_OFF_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    chk("master mode", 32'h1, 32'(master_mode));
    u_bus.start_cond();
    u_bus.xfer(8'hFF, 1'b0, rx, ak);
    chk("master header", 32'h92, 32'(rx));
    apb(1'b1, `SMB_OFF_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    chk("stop on request", 32'h1, 32'(stop_request));
    u_bus.stop_cond();
    chk("master after stop", 32'h0, 32'({master_mode, stop_request}));
    apb(1'b1, `SMB_OFF_CTRL, 32'h3);
    u_bus.start_cond();
    u_bus.xfer(8'hFF, 1'b1, rx, ak);
    repeat (2) @(posedge clk);
    chk("stop on nack", 32'h1, 32'(stop_request));
    u_bus.stop_cond();
    chk("idle after nack", 32'h0, 32'({master_mode, stop_request}));
    $display("master header done");
    test_done();
  end
endmodule : smb_byte_fsm_tb
